// ===== hdl/ltshd_bcd_field.sv
// One BCD stamp field: range check and masking of unused upper bits.
// Assumes the live value arrives on the same clock.
`timescale 1ns/1ns
module ltshd_bcd_field #(
    parameter int         MSB = 5,
    parameter logic [7:0] MIN = 8'h00,
    parameter logic [7:0] MAX = 8'h23
) (
    input  wire logic [7:0] value_i,
    output logic      [7:0] masked_o,
    output logic            valid_o
);
    // Refuse field widths narrower than one BCD digit or wider than one byte
    if (MSB < 3 || MSB > 7) begin : g_bad_msb
        $error("ltshd_bcd_field: MSB out of range");
    end

    always_comb begin
        masked_o = value_i & ((8'h01 << (MSB + 1)) - 8'h01);
        valid_o  = (masked_o[3:0] <= 4'h9) && (masked_o >= MIN)
                   && (masked_o <= MAX) && (masked_o == value_i);
    end
endmodule

// ===== hdl/ltshd_pkg.sv
// Package for the low-temperature hours/date stamp registers.
// Assumes an 8-bit host register port with byte addresses.
package ltshd_pkg;
    localparam logic [7:0] LTSHD_HOURS_ADDR  = 8'h1b;
    localparam logic [7:0] LTSHD_DATE_ADDR   = 8'h1c;
    localparam int         LTSHD_HOURS_MSB   = 5;
    localparam int         LTSHD_DATE_MSB    = 5;
    localparam logic [7:0] LTSHD_HOURS_RESET = 8'h00;
    localparam logic [7:0] LTSHD_DATE_RESET  = 8'h00;
    localparam logic [7:0] LTSHD_HOURS_MAX   = 8'h23;
    localparam logic [7:0] LTSHD_DATE_MIN    = 8'h01;
    localparam logic [7:0] LTSHD_DATE_MAX    = 8'h31;
    typedef enum logic [0:0] {
        LTSHD_KEEP_FIRST = 1'b0,
        LTSHD_KEEP_LAST  = 1'b1
    } ltshd_mode_t;
endpackage

// ===== hdl/ltshd_stamp.sv
// Low-temperature time stamp of hours and date, read-only to the host.
// Assumes capture, enable, select, clear and live calendar share clock_i.
`timescale 1ns/1ns

module ltshd_stamp (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       capture_i,
    input  wire logic       low_stamp_enable_i,
    input  wire logic       first_last_select_i,
    input  wire logic       stamp_clear_i,
    input  wire logic [7:0] live_hours_i,
    input  wire logic [7:0] live_date_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_rd_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic      [7:0] low_temp_stamp_hours_o,
    output logic      [7:0] low_temp_stamp_date_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] hours_r;
    logic [7:0] date_r;
    logic       held_r;
    logic [7:0] rdata_r;
    logic [7:0] hours_m;
    logic [7:0] date_m;
    logic       hours_ok;
    logic       date_ok;
    logic       take;
    logic       unused_wr;

    ltshd_bcd_field #(
        .MSB (ltshd_pkg::LTSHD_HOURS_MSB),
        .MIN (ltshd_pkg::LTSHD_HOURS_RESET),
        .MAX (ltshd_pkg::LTSHD_HOURS_MAX)
    ) u_hours (
        .value_i  (live_hours_i),
        .masked_o (hours_m),
        .valid_o  (hours_ok)
    );

    ltshd_bcd_field #(
        .MSB (ltshd_pkg::LTSHD_DATE_MSB),
        .MIN (ltshd_pkg::LTSHD_DATE_MIN),
        .MAX (ltshd_pkg::LTSHD_DATE_MAX)
    ) u_date (
        .value_i  (live_date_i),
        .masked_o (date_m),
        .valid_o  (date_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // Invalid live values are dropped whole so fields never disagree
    always_comb begin
        take = capture_i && low_stamp_enable_i && hours_ok && date_ok
               && (first_last_select_i == ltshd_pkg::LTSHD_KEEP_LAST
                   || !held_r);
    end

    // Host write port has no target here; kept only for the address map
    assign unused_wr = reg_wr_i & (|reg_wdata_i);

    // Clear wins over a same-cycle capture: software asked for empty
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hours_r <= ltshd_pkg::LTSHD_HOURS_RESET;
            date_r  <= ltshd_pkg::LTSHD_DATE_RESET;
            held_r  <= 1'b0;
        end else if (stamp_clear_i) begin
            hours_r <= ltshd_pkg::LTSHD_HOURS_RESET;
            date_r  <= ltshd_pkg::LTSHD_DATE_RESET;
            held_r  <= 1'b0;
        end else if (take) begin
            hours_r <= hours_m;
            date_r  <= date_m;
            held_r  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                ltshd_pkg::LTSHD_HOURS_ADDR: begin
                    rdata_r <= {2'b00, hours_r[5:0]};
                end
                ltshd_pkg::LTSHD_DATE_ADDR: begin
                    rdata_r <= {2'b00, date_r[5:0]};
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end

    assign reg_rdata_o            = rdata_r;
    assign low_temp_stamp_hours_o = hours_r;
    assign low_temp_stamp_date_o  = date_r;
endmodule

// ===== verif/ltshd_checker.sv
// Port checker for the hours/date stamp block.
// Assumes it is bound onto ltshd_stamp.
`timescale 1ns/1ns
module ltshd_checker (
    input wire logic       clock_i, rst_i, capture_i, reg_wr_i,
    input wire logic       low_stamp_enable_i, first_last_select_i,
    input wire logic       stamp_clear_i,
    input wire logic [7:0] live_hours_i, live_date_i,
    input wire logic [7:0] low_temp_stamp_hours_o, low_temp_stamp_date_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire [7:0] h  = live_hours_i;
    wire [7:0] d  = live_date_i;
    wire [7:0] sh = low_temp_stamp_hours_o;
    wire [7:0] sd = low_temp_stamp_date_o;
    // Clear wins over a same-cycle capture
    wire ok = h[3:0] < 4'ha && h < 8'h24 && d[3:0] < 4'ha && d != 8'h00
        && d < 8'h32 && !stamp_clear_i;
    wire take = capture_i && low_stamp_enable_i && ok;
    a_hours_top_zero: assert property (sh[7:6] == 2'b00)
        else $error("hours stamp upper bits set");
    a_hours_in_range: assert property (sh <= 8'h23)
        else $error("hours stamp out of range");
    a_write_no_effect: assert property (reg_wr_i && !capture_i
        && !stamp_clear_i |=> $stable(sh) && $stable(sd))
        else $error("host write changed a stamp");
    a_first_kept: assert property (take && !first_last_select_i
        && sd != 8'h00 |=> $stable(sh)) else $error("first stamp lost");
    a_clear_zeroes: assert property (stamp_clear_i |=> sh == 8'h00)
        else $error("clear left hours stamp");
    a_date_in_range: assert property (sd <= 8'h31 && sd[3:0] < 4'ha)
        else $error("date stamp out of range");
    a_pair_copied: assert property (take && first_last_select_i
        |=> sh == $past(h) && sd == $past(d)) else $error("stamp not copied");
    cover property (take && first_last_select_i);
    cover property (take && !first_last_select_i);
    cover property (stamp_clear_i);
endmodule
bind ltshd_stamp ltshd_checker u_chk (.*);

// ===== verif/testbench.sv
// Self-checking bench for the hours/date stamp block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ns
module testbench;
    logic clock_i = 0, rst_i = 1, capture_i = 0, stamp_clear_i = 0;
    logic low_stamp_enable_i = 1, first_last_select_i = 0;
    logic reg_rd_i = 0, reg_wr_i = 0;
    logic [7:0] live_hours_i = 0, live_date_i = 0, reg_addr_i = 0;
    logic [7:0] reg_wdata_i = 0, reg_rdata_o;
    logic [7:0] low_temp_stamp_hours_o, low_temp_stamp_date_o;
    int failures = 0, num_checks = 0;
    always #2 clock_i = ~clock_i;
    ltshd_stamp u_dut (.*);
    task chk(input logic [7:0] s, e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task rd(input logic [7:0] a, e);
        @(negedge clock_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(negedge clock_i) reg_rd_i = 0;
        chk(reg_rdata_o, e);
    endtask
    task cap(input logic [7:0] hv, dv, input logic en, sel);
        @(negedge clock_i) {live_hours_i, live_date_i} = {hv, dv};
        {low_stamp_enable_i, first_last_select_i, capture_i} = {en, sel, 1'b1};
        @(negedge clock_i) capture_i = 0;
    endtask
    task t_first;
        cap(8'h12, 8'h07, 1, 0);
        cap(8'h15, 8'h09, 1, 0);
        rd(8'h1b, 8'h12);
        rd(8'h1c, 8'h07);
    endtask
    task t_write;
        @(negedge clock_i) {reg_addr_i, reg_wdata_i} = 16'h1b_ff;
        reg_wr_i = 1;
        @(negedge clock_i) reg_addr_i = 8'h1c;
        @(negedge clock_i) reg_wr_i = 0;
        rd(8'h1b, 8'h12);
        rd(8'h1c, 8'h07);
        rd(8'h20, 8'h00);
    endtask
    task t_clear;
        @(negedge clock_i) stamp_clear_i = 1;
        @(negedge clock_i) stamp_clear_i = 0;
        rd(8'h1b, 8'h00);
        rd(8'h1c, 8'h00);
    endtask
    task t_last;
        cap(8'h23, 8'h31, 1, 1);
        rd(8'h1c, 8'h31);
        cap(8'h05, 8'h01, 1, 1);
        // Out-of-range and disabled events must not land
        cap(8'h24, 8'h10, 1, 1);
        cap(8'h1a, 8'h10, 1, 1);
        cap(8'h10, 8'h00, 1, 1);
        cap(8'h10, 8'h32, 1, 1);
        cap(8'h11, 8'h11, 0, 1);
        chk(low_temp_stamp_hours_o, 8'h05);
        chk(low_temp_stamp_date_o, 8'h01);
    endtask
    task wrap_up;
        if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clock_i);
        rst_i = 0;
        rd(8'h1b, 8'h00);
        t_first;
        t_write;
        t_clear;
        t_last;
        wrap_up;
    end
    initial begin
        #100000 failures++;
        wrap_up;
    end
endmodule
